// >>> cod_regs.vh
`ifndef COD_REGS_VH
`define COD_REGS_VH
// Register byte offsets on the bus
`define COD_REG_OPCODE 8'h00
`define COD_REG_OPER 8'h04
`define COD_REG_ACC 8'h08
`define COD_REG_IDX 8'h0C
`define COD_REG_CCR 8'h10
`define COD_REG_SP 8'h14
`define COD_REG_STAT 8'h18
// Condition-code bit positions
`define COD_CCR_H 4
`define COD_CCR_I 3
`define COD_CCR_N 2
`define COD_CCR_Z 1
`define COD_CCR_C 0
// Status bit positions
`define COD_ST_BUSY 0
`define COD_ST_TAKEN 1
`define COD_ST_LOWPWR 2
`define COD_ST_ILLEGAL 3
`define COD_ST_LEN_LSB 4
`define COD_ST_CYC_LSB 8
// Reset values
`define COD_SP_RST 8'hFF
`define COD_CCR_RST 5'h08
// Instruction classes
`define COD_CLS_ILL 4'h0
`define COD_CLS_REL 4'h1
`define COD_CLS_CALL 4'h2
`define COD_CLS_BTB 4'h3
`define COD_CLS_BSC 4'h4
`define COD_CLS_RMW 4'h5
`define COD_CLS_PROD 4'h6
`define COD_CLS_CTL 4'h7
// Lengths in bytes
`define COD_LEN_1 2'h1
`define COD_LEN_2 2'h2
`define COD_LEN_3 2'h3
// Cycle counts
`define COD_CYC_ILL 4'h1
`define COD_CYC_CTL 4'h2
`define COD_CYC_3 4'h3
`define COD_CYC_4 4'h4
`define COD_CYC_5 4'h5
`define COD_CYC_6 4'h6
`define COD_CYC_IRET 4'h9
`define COD_CYC_TRAP 4'hA
`define COD_CYC_PROD 4'hB
`endif

// >>> cod_class.v
`timescale 1ns/1ps
`include "cod_regs.vh"
module cod_class (
  input wire [7:0] opcode,
  output reg [3:0] cls,
  output reg [1:0] len,
  output reg [3:0] cyc
);
  wire [3:0] hi = opcode[7:4]; // Operand selector for read-modify-write
  wire [3:0] lo = opcode[3:0]; // Operation selector
  reg rmw_op; // Low nibble names a read-modify-write operation

  // Opcode to class, length and cycle count
  always @* begin
    rmw_op = (lo == 4'h0) || (lo == 4'h3) || (lo == 4'h4) || (lo == 4'h6) ||
             (lo == 4'h7) || (lo == 4'h8) || (lo == 4'h9) || (lo == 4'hA) ||
             (lo == 4'hC) || (lo == 4'hD) || (lo == 4'hF);
    cls = `COD_CLS_ILL;
    len = `COD_LEN_1;
    cyc = `COD_CYC_ILL;
    if (hi == 4'h0) begin
      // Bit test and jump
      cls = `COD_CLS_BTB; len = `COD_LEN_3; cyc = `COD_CYC_5;
    end else if (hi == 4'h1) begin
      // Direct bit set or clear
      cls = `COD_CLS_BSC; len = `COD_LEN_2; cyc = `COD_CYC_5;
    end else if (hi == 4'h2) begin
      // Relative branches
      cls = `COD_CLS_REL; len = `COD_LEN_2; cyc = `COD_CYC_3;
    end else if (opcode == 8'hAD) begin
      cls = `COD_CLS_CALL; len = `COD_LEN_2; cyc = `COD_CYC_6;
    end else if (opcode == 8'h42) begin
      cls = `COD_CLS_PROD; len = `COD_LEN_1; cyc = `COD_CYC_PROD;
    end else if (rmw_op && (hi == 4'h4 || hi == 4'h5)) begin
      cls = `COD_CLS_RMW; len = `COD_LEN_1; cyc = `COD_CYC_3;
    end else if (rmw_op && (hi == 4'h3 || hi == 4'h7)) begin
      // Direct and indexed; test reads only, so one cycle less
      cls = `COD_CLS_RMW;
      len = (hi == 4'h3) ? `COD_LEN_2 : `COD_LEN_1;
      cyc = (lo == 4'hD) ? `COD_CYC_4 : `COD_CYC_5;
    end else if (rmw_op && hi == 4'h6) begin
      cls = `COD_CLS_RMW; len = `COD_LEN_2;
      cyc = (lo == 4'hD) ? `COD_CYC_5 : `COD_CYC_6;
    end else if (opcode == 8'h83) begin
      cls = `COD_CLS_CTL; cyc = `COD_CYC_TRAP;
    end else if (opcode == 8'h81) begin
      cls = `COD_CLS_CTL; cyc = `COD_CYC_6;
    end else if (opcode == 8'h80) begin
      cls = `COD_CLS_CTL; cyc = `COD_CYC_IRET;
    end else if ((opcode >= 8'h97 && opcode <= 8'h9D) || opcode == 8'h9F ||
                 opcode == 8'h8E || opcode == 8'h8F) begin
      // Two-cycle inherent group
      cls = `COD_CLS_CTL; cyc = `COD_CYC_CTL;
    end
  end
endmodule // cod_class

// >>> cod_alu.v
`timescale 1ns/1ps
module cod_alu (
  input wire [3:0] op,
  input wire [7:0] din,
  input wire cin,
  output reg [7:0] dout,
  output reg cout,
  output reg wr
);
  // Read-modify-write operations by low nibble
  always @* begin
    dout = din;
    cout = cin;
    wr = 1'b1;
    case (op)
      4'h0: begin
        dout = (~din) + 8'h01;
        cout = (din != 8'h00);
      end
      4'h3: begin
        dout = ~din;
        cout = 1'b1;
      end
      4'h4: begin
        dout = {1'b0, din[7:1]};
        cout = din[0];
      end
      4'h6: begin
        dout = {cin, din[7:1]};
        cout = din[0];
      end
      4'h7: begin
        dout = {din[7], din[7:1]};
        cout = din[0];
      end
      4'h8: begin
        dout = {din[6:0], 1'b0};
        cout = din[7];
      end
      4'h9: begin
        dout = {din[6:0], cin};
        cout = din[7];
      end
      4'hA: dout = din - 8'h01;
      4'hC: dout = din + 8'h01;
      4'hF: dout = 8'h00;
      // Test only looks, never writes back
      default: wr = 1'b0;
    endcase
  end
endmodule // cod_alu

// >>> cod_top.v
`timescale 1ns/1ps
`include "cod_regs.vh"
// Functional notes
// - relative branches 20-2F, two bytes, three cycles
// - 24 carry clear, 25 carry set
// - 28/29 branch on half-carry clear/set
// - 2C/2D branch on mask clear/set
// - 2E/2F branch on interrupt line low/high
// - AD relative call, two bytes, six cycles
// - bit test jumps 2n/01+2n, three bytes, five
// - bit set/clear 10+2n/11+2n, two bytes, five
// - high nibble operand, low nibble operation
// - RMW lengths and cycles per operand form
// - test operation D, shorter memory timings
// - 9B sets mask, 99 sets carry
// - 9A clears mask, 98 clears carry
// - trap 10, return 6, interrupt return 9
// - 42 multiplies index by accumulator, eleven cycles
module cod_top (
  input wire CORE_CLK,
  input wire ARST_N,
  // Register bus, classic single cycle
  input wire WB_CYC_I,
  input wire WB_STB_I,
  input wire WB_WE_I,
  input wire [7:0] WB_ADR_I,
  input wire [3:0] WB_SEL_I,
  input wire [31:0] WB_DAT_I,
  output reg [31:0] WB_DAT_O,
  output reg WB_ACK_O,
  // Interrupt line, taken as already synchronous to the core clock
  input wire IRQ_LINE,
  // Instruction status, all registered
  output reg BUSY,
  output reg BRANCH_TAKEN,
  output reg LOW_POWER,
  output reg DONE
);
  // Two states suffice: every instruction is a fixed count
  localparam ST_IDLE = 1'b0; // Waiting for an opcode
  localparam ST_EXEC = 1'b1; // Spending the instruction's cycles

  reg state_ff; // Sequencer state
  reg nxt_state;
  reg [3:0] cnt_ff; // Cycles left in the instruction
  reg [3:0] nxt_cnt;
  reg [7:0] opc_ff; // Opcode being executed
  reg [3:0] cls_ff; // Its class
  reg [1:0] len_ff; // Its length in bytes
  reg [3:0] cyc_ff; // Its total cycle count
  reg [7:0] acc_ff; // Accumulator
  reg [7:0] idx_ff; // Index register
  reg [7:0] oper_ff; // Memory operand byte
  reg [7:0] sp_ff; // Stack pointer
  reg [4:0] ccr_ff; // Condition codes H I N Z C
  reg taken_ff; // Last branch decision
  reg lowpwr_ff; // Low-power state after stop or wait
  reg illegal_ff; // Last opcode was not in the map
  reg ack_ff; // Bus answer
  reg [31:0] rdat_ff; // Bus read data
  reg busy_ff; // Mirror of the exec state for the pin
  reg done_ff; // One-cycle end pulse

  wire [3:0] dcd_cls; // Decode of the byte on the bus
  wire [1:0] dcd_len;
  wire [3:0] dcd_cyc;
  wire [7:0] alu_out; // Read-modify-write result
  wire alu_c;
  wire alu_wr;
  reg [7:0] alu_in; // Operand chosen by the high nibble
  reg cond; // Branch condition for the held opcode
  wire [15:0] product; // Index times accumulator
  wire bus_req; // New request this cycle
  wire bus_wr; // Write taking effect
  wire last; // Final cycle of the instruction
  wire op_start; // Opcode write accepted
  wire idle_wr; // Register write allowed: no instruction in flight

  assign bus_req = WB_CYC_I & WB_STB_I & ~ack_ff;
  assign bus_wr = bus_req & WB_WE_I & WB_SEL_I[0];
  // Opcode writes while busy are dropped, not queued
  assign op_start = bus_wr & (WB_ADR_I == `COD_REG_OPCODE) & (state_ff == ST_IDLE);
  assign last = (state_ff == ST_EXEC) & (cnt_ff == 4'h1);
  // Registers are frozen while counting so results cannot be overwritten
  assign idle_wr = bus_wr & (state_ff == ST_IDLE);
  assign product = idx_ff * acc_ff;

  // Held opcode works on the accumulator or index, not on memory
  function reg_form;
    input [7:0] opc;
    begin
      reg_form = (opc[7:4] == 4'h4) || (opc[7:4] == 4'h5);
    end
  endfunction

  // Decode straight off the write data so timing starts at once
  cod_class u_class (
    .opcode(WB_DAT_I[7:0]),
    .cls(dcd_cls),
    .len(dcd_len),
    .cyc(dcd_cyc)
  );

  // Operand select by high nibble
  always @* begin
    if (opc_ff[7:4] == 4'h4) begin
      alu_in = acc_ff;
    end else if (opc_ff[7:4] == 4'h5) begin
      alu_in = idx_ff;
    end else begin
      alu_in = oper_ff;
    end
  end

  cod_alu u_alu (
    .op(opc_ff[3:0]),
    .din(alu_in),
    .cin(ccr_ff[`COD_CCR_C]),
    .dout(alu_out),
    .cout(alu_c),
    .wr(alu_wr)
  );

  // Branch condition, decided from flags at the last cycle
  // The line is read with no extra flop, so the decision sees it
  // exactly at the final cycle; a glitchy line must be cleaned outside
  always @* begin
    cond = 1'b0;
    if (cls_ff == `COD_CLS_BTB) begin
      // Even opcode jumps on a set bit, odd on a clear one
      cond = oper_ff[opc_ff[3:1]] ^ opc_ff[0];
    end else if (cls_ff == `COD_CLS_CALL) begin
      cond = 1'b1;
    end else if (cls_ff == `COD_CLS_REL) begin
      case (opc_ff[3:0])
        4'h0: cond = 1'b1;
        4'h1: cond = 1'b0;
        4'h2: cond = ~(ccr_ff[`COD_CCR_C] | ccr_ff[`COD_CCR_Z]);
        4'h3: cond = ccr_ff[`COD_CCR_C] | ccr_ff[`COD_CCR_Z];
        4'h4: cond = ~ccr_ff[`COD_CCR_C];
        4'h5: cond = ccr_ff[`COD_CCR_C];
        4'h6: cond = ~ccr_ff[`COD_CCR_Z];
        4'h7: cond = ccr_ff[`COD_CCR_Z];
        4'h8: cond = ~ccr_ff[`COD_CCR_H];
        4'h9: cond = ccr_ff[`COD_CCR_H];
        4'hA: cond = ~ccr_ff[`COD_CCR_N];
        4'hB: cond = ccr_ff[`COD_CCR_N];
        4'hC: cond = ~ccr_ff[`COD_CCR_I];
        4'hD: cond = ccr_ff[`COD_CCR_I];
        4'hE: cond = ~IRQ_LINE;
        default: cond = IRQ_LINE;
      endcase
    end
  end

  // Sequencer next state: count the instruction's cycles down
  always @* begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      ST_IDLE: begin
        if (op_start) begin
          nxt_state = ST_EXEC;
          nxt_cnt = dcd_cyc;
        end
      end
      default: begin
        // Counting down; the last cycle commits results
        nxt_cnt = cnt_ff - 4'h1;
        if (cnt_ff == 4'h1) begin
          nxt_state = ST_IDLE;
        end
      end
    endcase
  end

  // Sequencer flops and latched decode
  always @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 4'h0;
      opc_ff <= 8'h00;
      cls_ff <= `COD_CLS_ILL;
      len_ff <= 2'h0;
      cyc_ff <= 4'h0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      busy_ff <= (nxt_state == ST_EXEC);
      done_ff <= last;
      if (op_start) begin
        opc_ff <= WB_DAT_I[7:0];
        cls_ff <= dcd_cls;
        len_ff <= dcd_len;
        cyc_ff <= dcd_cyc;
      end
    end
  end

  // Result flags; taken and low-power entry commit on the last cycle, illegal is set at opcode start
  always @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      taken_ff <= 1'b0;
      lowpwr_ff <= 1'b0;
      illegal_ff <= 1'b0;
    end else begin
      if (op_start) begin
        // A new opcode is also the wake-up from low power
        lowpwr_ff <= 1'b0;
        illegal_ff <= (dcd_cls == `COD_CLS_ILL);
      end else if (last) begin
        taken_ff <= cond;
        if (opc_ff == 8'h8E || opc_ff == 8'h8F) begin
          lowpwr_ff <= 1'b1;
        end
      end
    end
  end

  // Accumulator and index: bus writes when idle, results at commit
  always @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      acc_ff <= 8'h00;
      idx_ff <= 8'h00;
    end else if (last) begin
      if (cls_ff == `COD_CLS_PROD) begin
        idx_ff <= product[15:8];
        acc_ff <= product[7:0];
      end else if (cls_ff == `COD_CLS_RMW && alu_wr && opc_ff[7:4] == 4'h4) begin
        acc_ff <= alu_out;
      end else if (cls_ff == `COD_CLS_RMW && alu_wr && opc_ff[7:4] == 4'h5) begin
        idx_ff <= alu_out;
      end else if (opc_ff == 8'h97) begin
        idx_ff <= acc_ff;
      end else if (opc_ff == 8'h9F) begin
        acc_ff <= idx_ff;
      end
    end else if (idle_wr) begin
      if (WB_ADR_I == `COD_REG_ACC) begin
        acc_ff <= WB_DAT_I[7:0];
      end else if (WB_ADR_I == `COD_REG_IDX) begin
        idx_ff <= WB_DAT_I[7:0];
      end
    end
  end

  // Memory operand byte and stack pointer
  always @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      oper_ff <= 8'h00;
      sp_ff <= `COD_SP_RST;
    end else if (last) begin
      if (cls_ff == `COD_CLS_BSC) begin
        // Even opcode sets the bit, odd clears it
        oper_ff[opc_ff[3:1]] <= ~opc_ff[0];
      end else if (cls_ff == `COD_CLS_RMW && alu_wr && !reg_form(opc_ff)) begin
        oper_ff <= alu_out;
      end else if (opc_ff == 8'h9C) begin
        sp_ff <= `COD_SP_RST;
      end
    end else if (idle_wr) begin
      if (WB_ADR_I == `COD_REG_OPER) begin
        oper_ff <= WB_DAT_I[7:0];
      end else if (WB_ADR_I == `COD_REG_SP) begin
        sp_ff <= WB_DAT_I[7:0];
      end
    end
  end

  // Condition codes
  always @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ccr_ff <= `COD_CCR_RST;
    end else if (last) begin
      if (cls_ff == `COD_CLS_RMW) begin
        ccr_ff[`COD_CCR_N] <= alu_out[7];
        ccr_ff[`COD_CCR_Z] <= (alu_out == 8'h00);
        ccr_ff[`COD_CCR_C] <= alu_c;
      end else if (cls_ff == `COD_CLS_BTB) begin
        // Tested bit lands in carry
        ccr_ff[`COD_CCR_C] <= oper_ff[opc_ff[3:1]];
      end else if (cls_ff == `COD_CLS_PROD) begin
        ccr_ff[`COD_CCR_H] <= 1'b0;
        ccr_ff[`COD_CCR_C] <= 1'b0;
      end else if (opc_ff == 8'h9B || opc_ff == 8'h83) begin
        ccr_ff[`COD_CCR_I] <= 1'b1;
      end else if (opc_ff == 8'h99) begin
        ccr_ff[`COD_CCR_C] <= 1'b1;
      end else if (opc_ff == 8'h9A) begin
        ccr_ff[`COD_CCR_I] <= 1'b0;
      end else if (opc_ff == 8'h98) begin
        ccr_ff[`COD_CCR_C] <= 1'b0;
      end
    end else if (idle_wr && WB_ADR_I == `COD_REG_CCR) begin
      ccr_ff <= WB_DAT_I[4:0];
    end
  end

  // Status is a snapshot of the last instruction, not live decode
  // Bus read mux; unmapped reads return zero
  always @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rdat_ff <= 32'h00000000;
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= bus_req;
      rdat_ff <= 32'h00000000;
      if (bus_req && !WB_WE_I) begin
        if (WB_ADR_I == `COD_REG_OPCODE) begin
          rdat_ff <= {24'h000000, opc_ff};
        end else if (WB_ADR_I == `COD_REG_OPER) begin
          rdat_ff <= {24'h000000, oper_ff};
        end else if (WB_ADR_I == `COD_REG_ACC) begin
          rdat_ff <= {24'h000000, acc_ff};
        end else if (WB_ADR_I == `COD_REG_IDX) begin
          rdat_ff <= {24'h000000, idx_ff};
        end else if (WB_ADR_I == `COD_REG_CCR) begin
          rdat_ff <= {27'h0, ccr_ff};
        end else if (WB_ADR_I == `COD_REG_SP) begin
          rdat_ff <= {24'h000000, sp_ff};
        end else if (WB_ADR_I == `COD_REG_STAT) begin
          rdat_ff[`COD_ST_BUSY] <= busy_ff;
          rdat_ff[`COD_ST_TAKEN] <= taken_ff;
          rdat_ff[`COD_ST_LOWPWR] <= lowpwr_ff;
          rdat_ff[`COD_ST_ILLEGAL] <= illegal_ff;
          rdat_ff[`COD_ST_LEN_LSB+1:`COD_ST_LEN_LSB] <= len_ff;
          rdat_ff[`COD_ST_CYC_LSB+3:`COD_ST_CYC_LSB] <= cyc_ff;
        end
      end
    end
  end

  // Outputs straight from flops
  always @* begin
    WB_DAT_O = rdat_ff;
    WB_ACK_O = ack_ff;
    BUSY = busy_ff;
    BRANCH_TAKEN = taken_ff;
    LOW_POWER = lowpwr_ff;
    DONE = done_ff;
  end
endmodule // cod_top

// >>> cod_top_checker.sv
`timescale 1ns/1ps
// Bus handshake and instruction timing seen at the pins
module cod_checker (
  input wire CORE_CLK,
  input wire ARST_N,
  input wire WB_CYC_I,
  input wire WB_STB_I,
  input wire WB_WE_I,
  input wire [7:0] WB_ADR_I,
  input wire [3:0] WB_SEL_I,
  input wire [31:0] WB_DAT_I,
  input wire [31:0] WB_DAT_O,
  input wire WB_ACK_O,
  input wire IRQ_LINE,
  input wire BUSY,
  input wire BRANCH_TAKEN,
  input wire LOW_POWER,
  input wire DONE
);
  // Opcode write that really starts work; writes while busy are dropped
  wire go = WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O && (WB_ADR_I == 8'h00)
    && WB_SEL_I[0] && !BUSY;
  wire [7:0] op = WB_DAT_I[7:0]; // Opcode on the bus
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);
  ack_follows_req_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("request without ack");
  ack_one_cycle_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack too long");
  rel_timing_a: assert property (go && op[7:4] == 4'h2 |=> BUSY[*3] ##1 (!BUSY && DONE))
    else $error("branch timing");
  call_timing_a: assert property (go && op == 8'hAD |=> BUSY[*6] ##1 (DONE && BRANCH_TAKEN))
    else $error("call timing");
  bit_timing_a: assert property (go && op[7:5] == 3'b000 |=> BUSY[*5] ##1 !BUSY)
    else $error("bit op timing");
  product_timing_a: assert property (go && op == 8'h42 |=> BUSY[*8] ##1 BUSY[*3] ##1 !BUSY)
    else $error("multiply timing");
  trap_timing_a: assert property (go && op == 8'h83 |=> BUSY[*8] ##1 BUSY[*2] ##1 !BUSY)
    else $error("trap timing");
  ctl_timing_a: assert property (go && op inside {[8'h97:8'h9D], 8'h9F} |=> BUSY[*2] ##1 !BUSY)
    else $error("control timing");
  sleep_entry_a: assert property (go && op[7:1] == 7'h47 |=> BUSY[*2] ##1 LOW_POWER)
    else $error("low power entry");
  done_at_end_a: assert property ($fell(BUSY) |-> DONE)
    else $error("end without done");
  taken_at_end_a: assert property ($changed(BRANCH_TAKEN) |-> DONE)
    else $error("taken changed early");
  line_high_branch_a: assert property (go && op == 8'h2F |-> ##4 (BRANCH_TAKEN == $past(IRQ_LINE)))
    else $error("line branch wrong");
  read_data_idle_a: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h00000000)
    else $error("read data without ack");
endmodule // cod_checker

bind cod_top cod_checker u_cod_checker (.CORE_CLK, .ARST_N, .WB_CYC_I, .WB_STB_I, .WB_WE_I,
  .WB_ADR_I, .WB_SEL_I, .WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .IRQ_LINE, .BUSY, .BRANCH_TAKEN,
  .LOW_POWER, .DONE);

// >>> cod_pmem.sv
`timescale 1ns/1ps
// Program store holding the control opcode sequence, one byte per slot
module cod_pmem (
  input wire [3:0] addr,
  output wire [7:0] data
);
  // Flag ops first so their effects can be read back in order
  localparam [103:0] IMG = 104'h999B989A979F9C9D8381808E8F;
  assign data = IMG[103 - 8 * addr -: 8];
endmodule // cod_pmem

// >>> cod_tb.sv
`timescale 1ns/1ps
// Drives the register bus, times every mapped opcode except 42, 13, 17, 1B and 1F and checks results
module tb_top;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic irq = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [3:0] pm_addr = 4'h0;
  wire [7:0] pm_data;
  wire [31:0] rdat;
  wire ack, busy, taken, lowp, done;
  int n_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  always #5 clk = ~clk;
  cod_top u_cod_top (.CORE_CLK(clk), .ARST_N(arst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .IRQ_LINE(irq), .BUSY(busy), .BRANCH_TAKEN(taken), .LOW_POWER(lowp),
    .DONE(done));
  cod_pmem u_cod_pmem (.addr(pm_addr), .data(pm_data));
  task automatic give_verdict;
    if (n_errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Ceiling well above the whole sequence
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      give_verdict;
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One classic cycle; request held until ack is sampled, then one idle cycle
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
      input logic [3:0] s, output logic [31:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    sel <= s;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    chk(ack, 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, 4'hF, q);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    xfer(1'b0, a, 8'h00, 4'hF, q);
    chk(q, exp);
  endtask
  // Start an opcode, count cycles to the done pulse, then check status fields
  task automatic run(input logic [7:0] op, input logic [3:0] nc, input logic [1:0] nl);
    logic [31:0] q;
    int n;
    wr(8'h00, op);
    n = 1;
    while (done !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    chk(32'(n), {28'h0, nc});
    xfer(1'b0, 8'h18, 8'h00, 4'hF, q);
    chk({26'h0, q[11:8], q[5:4]}, {26'h0, nc, nl});
  endtask
  task automatic s_reset;
    logic [31:0] q;
    rd_chk(8'h10, 32'h08);
    rd_chk(8'h14, 32'hFF);
    wr(8'h1C, 8'hA5); // Unmapped: acked, dropped
    rd_chk(8'h1C, 32'h00);
    xfer(1'b1, 8'h08, 8'h5A, 4'hE, q); // Low byte lane off: dropped
    rd_chk(8'h08, 32'h00);
  endtask
  // All flags clear, then all set with the line high
  task automatic s_branch;
    logic e;
    for (int p = 0; p < 2; p++) begin
      wr(8'h10, p[0] ? 8'h1F : 8'h00);
      irq <= p[0];
      for (int k = 0; k < 16; k++) begin
        run(8'(8'h20 + k), 4'h3, 2'h2);
        e = p[0] ? (k == 0 || (k % 2 == 1 && k != 1)) : (k % 2 == 0);
        chk(taken, e);
      end
    end
    run(8'hAD, 4'h6, 2'h2);
    chk(taken, 1'b1);
  endtask
  task automatic s_bits;
    logic [7:0] m;
    m = 8'h00;
    wr(8'h04, 8'h00);
    for (int n = 0; n < 8; n++) begin
      run(8'(8'h10 + 2 * n), 4'h5, 2'h2);
      m[n] = 1'b1;
      if (n % 2 == 0) begin
        run(8'(8'h11 + 2 * n), 4'h5, 2'h2);
        m[n] = 1'b0;
      end
      rd_chk(8'h04, {24'h0, m});
    end
    for (int n = 0; n < 8; n++) begin
      run(8'(2 * n), 4'h5, 2'h3);
      chk(taken, m[n]);
      run(8'(2 * n + 1), 4'h5, 2'h3);
      chk(taken, !m[n]);
    end
  endtask
  // Every operand form against every operation
  task automatic s_rmw;
    logic [19:0] hi = 20'h45376;
    logic [19:0] cy = 20'h33556;
    logic [19:0] ct = 20'h33445;
    logic [9:0] ln = 10'b0101100110;
    logic [43:0] lo = 44'h0346789ACFD;
    logic [3:0] l;
    for (int f = 0; f < 5; f++) begin
      for (int k = 0; k < 11; k++) begin
        l = lo[43 - 4 * k -: 4];
        run({hi[19 - 4 * f -: 4], l}, (l == 4'hD) ? ct[19 - 4 * f -: 4] : cy[19 - 4 * f -: 4],
          ln[9 - 2 * f -: 2]);
      end
    end
    wr(8'h08, 8'h81);
    run(8'h44, 4'h3, 2'h1);
    rd_chk(8'h08, 32'h40);
    wr(8'h04, 8'h01);
    run(8'h30, 4'h5, 2'h2);
    rd_chk(8'h04, 32'hFF);
  endtask
  task automatic s_product;
    int t;
    wr(8'h0C, 8'h10);
    wr(8'h08, 8'h12);
    wr(8'h10, 8'h1F);
    wr(8'h00, 8'h42);
    wr(8'h08, 8'h55); // Busy: must be dropped
    t = 0;
    while (done !== 1'b1 && t < 40) begin
      @(posedge clk);
      t++;
    end
    rd_chk(8'h08, 32'h20);
    rd_chk(8'h0C, 32'h01);
    rd_chk(8'h10, 32'h0E);
  endtask
  task automatic s_ctl;
    logic [51:0] cy = 52'h22222222A6922;
    logic [31:0] cc = 32'h01090800;
    wr(8'h10, 8'h00);
    wr(8'h08, 8'h5A);
    wr(8'h14, 8'h3C);
    for (int i = 0; i < 13; i++) begin
      pm_addr = 4'(i);
      @(posedge clk);
      run(pm_data, cy[51 - 4 * i -: 4], 2'h1);
      if (i < 4) begin
        rd_chk(8'h10, {24'h0, cc[31 - 8 * i -: 8]});
      end
    end
    chk(lowp, 1'b1);
    rd_chk(8'h0C, 32'h5A);
    rd_chk(8'h14, 32'hFF);
    run(8'h9D, 4'h2, 2'h1);
    chk(lowp, 1'b0);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    s_reset();
    s_branch();
    s_bits();
    s_rmw();
    s_product();
    s_ctl();
    give_verdict;
  end
endmodule // tb_top
